// ### adc_control_registers.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Done flag sets per conversion; clears on access
// - Done flag reads zero while interrupt enabled
// - Interrupt request per conversion when enabled
// - Continuous bit repeats conversions, else one
// - Codes 0 to 11 pick external channels
// - Codes 12 to 26 unknown; 27,28 reserved
// - Codes 29 and 30 select internal references
// - All-ones channel powers down; reset value
// - One 8-bit result loaded per conversion
// - Prescaler divides by 1,2,4,8 or 16
// - Source bit picks bus or crystal clock
// - Sixteen ticks, start at tick after write
// - Continuous results overwrite unread results
// - Stop state aborts conversion; continuous mode resumes afterwards
module adc_control_registers (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	output logic irq_o,
	input wire logic crystal_clock_i,
	input wire logic stop_mode_i,
	input wire logic comparator_i,
	output logic [4:0] channel_select_o,
	output logic power_down_o,
	output logic ref_high_sel_o,
	output logic ref_low_sel_o,
	output logic external_sel_o,
	output logic sample_o,
	output logic [7:0] dac_code_o,
	output logic busy_o
);

	adc_ctrl_pkg::ctrl_s ctrl_reg;
	adc_ctrl_pkg::clk_cfg_s clk_cfg_reg;
	adc_ctrl_pkg::conv_state_e state_reg;
	logic done_flag_reg;
	logic [7:0] result_reg;
	logic result_unread_reg;
	logic start_pending_reg;
	logic [3:0] tick_count_reg;
	logic [7:0] trial_reg;
	logic [7:0] irq_status_reg;
	logic [7:0] irq_enable_reg;
	logic conv_tick;
	logic conv_done;
	logic conv_abort;
	logic wr_ctrl;
	logic rd_result;
	logic wr_clear;
	logic wr_clk_cfg;
	logic wr_irq_enable;
	logic access_clear;
	logic powered_off;
	logic [7:0] trial_bit;
	logic [7:0] status_read;
	logic [7:0] clk_cfg_read;
	logic [7:0] rd_next;
	logic [7:0] irq_set;
	logic [7:0] irq_clear;

	// Register port decode
	assign wr_ctrl = wr_i && (addr_i == adc_ctrl_pkg::STATUS_CONTROL_ADDR);
	assign rd_result = rd_i && (addr_i == adc_ctrl_pkg::RESULT_ADDR);
	assign wr_clk_cfg = wr_i && (addr_i == adc_ctrl_pkg::CLOCK_CONFIG_ADDR);
	assign wr_clear = wr_i && (addr_i == adc_ctrl_pkg::IRQ_CLEAR_ADDR);
	assign wr_irq_enable = wr_i && (addr_i == adc_ctrl_pkg::IRQ_ENABLE_ADDR);

	// Either access counts as acknowledgement of the last result
	assign access_clear = wr_ctrl | rd_result;
	assign powered_off = adc_ctrl_pkg::channel_off(ctrl_reg.channel);

	// Converter clock from bus or crystal source
	adc_prescaler prescaler_inst (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.crystal_clock_i(crystal_clock_i),
		.cfg_i(clk_cfg_reg),
		.tick_o(conv_tick)
	);

	// Status/control register; reset leaves the converter powered off
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_reg <= adc_ctrl_pkg::ctrl_s'(adc_ctrl_pkg::STATUS_CONTROL_RESET[6:0]);
		end else if (wr_ctrl) begin
			ctrl_reg.irq_enable <= wr_data_i[adc_ctrl_pkg::IRQ_EN_BIT];
			ctrl_reg.continuous <= wr_data_i[adc_ctrl_pkg::CONT_BIT];
			ctrl_reg.channel <= wr_data_i[adc_ctrl_pkg::CHANNEL_LSB +: 5];
		end
	end

	// Clock configuration; no interlock against a change mid-conversion
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_cfg_reg.prescale <=
				adc_ctrl_pkg::CLOCK_CONFIG_RESET[adc_ctrl_pkg::PRESCALE_LSB +: 3];
			clk_cfg_reg.source_bus <=
				adc_ctrl_pkg::CLOCK_CONFIG_RESET[adc_ctrl_pkg::CLK_SRC_BIT];
		end else if (wr_clk_cfg) begin
			clk_cfg_reg.prescale <= wr_data_i[adc_ctrl_pkg::PRESCALE_LSB +: 3];
			clk_cfg_reg.source_bus <= wr_data_i[adc_ctrl_pkg::CLK_SRC_BIT];
		end
	end

	// Stop state or power-off kills any conversion in flight
	assign conv_abort = (stop_mode_i || powered_off) && (state_reg != adc_ctrl_pkg::CONV_IDLE);
	assign conv_done = conv_tick && (state_reg == adc_ctrl_pkg::CONV_APPROX)
		&& (tick_count_reg == adc_ctrl_pkg::CONV_LAST_TICK) && !conv_abort;

	// Start request; taken on the next converter tick
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			start_pending_reg <= 1'b0;
		end else if (wr_ctrl) begin
			start_pending_reg <= !adc_ctrl_pkg::channel_off(wr_data_i[4:0]);
		end else if (powered_off) begin
			start_pending_reg <= 1'b0;
		end else if (stop_mode_i) begin
			// Continuous mode keeps its request so it resumes after stop
			start_pending_reg <= ctrl_reg.continuous;
		end else if (conv_done) begin
			start_pending_reg <= ctrl_reg.continuous;
		end else if (conv_tick && state_reg == adc_ctrl_pkg::CONV_IDLE) begin
			start_pending_reg <= 1'b0;
		end
	end

	// Bit under trial in the approximation phase
	always_comb begin
		trial_bit = 8'h00;
		if (tick_count_reg > adc_ctrl_pkg::SAMPLE_LAST_TICK) begin
			trial_bit = adc_ctrl_pkg::SAR_FIRST_TRIAL >> (tick_count_reg[2:0]);
		end
	end

	// Conversion sequencer: seven sample ticks, nine approximation ticks
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= adc_ctrl_pkg::CONV_IDLE;
			tick_count_reg <= 4'h0;
			trial_reg <= 8'h00;
		end else if (conv_abort) begin
			state_reg <= adc_ctrl_pkg::CONV_IDLE;
			tick_count_reg <= 4'h0;
			trial_reg <= 8'h00;
		end else if (conv_tick) begin
			case (state_reg)
				adc_ctrl_pkg::CONV_IDLE: begin
					if (start_pending_reg && !stop_mode_i && !powered_off) begin
						state_reg <= adc_ctrl_pkg::CONV_SAMPLE;
						tick_count_reg <= 4'h0;
						trial_reg <= 8'h00;
					end
				end
				adc_ctrl_pkg::CONV_SAMPLE: begin
					tick_count_reg <= tick_count_reg + 4'h1;
					if (tick_count_reg == adc_ctrl_pkg::SAMPLE_LAST_TICK - 4'h1) begin
						state_reg <= adc_ctrl_pkg::CONV_APPROX;
						trial_reg <= adc_ctrl_pkg::SAR_FIRST_TRIAL;
					end
				end
				adc_ctrl_pkg::CONV_APPROX: begin
					// Comparator low means the trial value overshot
					trial_reg <= (comparator_i ? trial_reg : (trial_reg & ~trial_bit))
						| (trial_bit >> 1);
					if (tick_count_reg == adc_ctrl_pkg::CONV_LAST_TICK) begin
						state_reg <= adc_ctrl_pkg::CONV_IDLE;
						tick_count_reg <= 4'h0;
					end else begin
						tick_count_reg <= tick_count_reg + 4'h1;
					end
				end
				default: begin
					state_reg <= adc_ctrl_pkg::CONV_IDLE;
					tick_count_reg <= 4'h0;
				end
			endcase
		end
	end

	// Result register; always overwritten, read or not
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			result_reg <= adc_ctrl_pkg::RESULT_RESET;
		end else if (conv_done) begin
			result_reg <= comparator_i ? trial_reg : (trial_reg & ~trial_bit);
		end
	end

	// Tracks whether software has read the newest result
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			result_unread_reg <= 1'b0;
		end else if (conv_done) begin
			result_unread_reg <= 1'b1;
		end else if (rd_result) begin
			result_unread_reg <= 1'b0;
		end
	end

	// Done flag; a completion in the clearing cycle wins
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_flag_reg <= 1'b0;
		end else if (conv_done && !ctrl_reg.irq_enable) begin
			done_flag_reg <= 1'b1;
		end else if (access_clear) begin
			done_flag_reg <= 1'b0;
		end
	end

	// Event sources for the sticky status
	always_comb begin
		irq_set = 8'h00;
		irq_set[adc_ctrl_pkg::IRQ_DONE_BIT] = conv_done && ctrl_reg.irq_enable;
		irq_set[adc_ctrl_pkg::IRQ_OVERRUN_BIT] = conv_done && result_unread_reg
			&& !rd_result;
		irq_set[adc_ctrl_pkg::IRQ_ABORT_BIT] = conv_abort && stop_mode_i;
		irq_clear = wr_clear ? wr_data_i : 8'h00;
		irq_clear[adc_ctrl_pkg::IRQ_DONE_BIT] = irq_clear[adc_ctrl_pkg::IRQ_DONE_BIT]
			| access_clear;
	end

	// Sticky status; set beats clear so no event is lost
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_status_reg <= 8'h00;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_enable_reg <= adc_ctrl_pkg::IRQ_ENABLE_RESET;
		end else if (wr_irq_enable) begin
			irq_enable_reg <= wr_data_i;
		end
	end

	// Level interrupt, one cycle behind the status for a clean flop output
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_reg & irq_enable_reg);
		end
	end

	// Read views
	always_comb begin
		status_read = {1'b0, ctrl_reg};
		status_read[adc_ctrl_pkg::DONE_BIT] = done_flag_reg && !ctrl_reg.irq_enable;
		clk_cfg_read = 8'h00;
		clk_cfg_read[adc_ctrl_pkg::PRESCALE_LSB +: 3] = clk_cfg_reg.prescale;
		clk_cfg_read[adc_ctrl_pkg::CLK_SRC_BIT] = clk_cfg_reg.source_bus;
		case (addr_i)
			adc_ctrl_pkg::STATUS_CONTROL_ADDR: rd_next = status_read;
			adc_ctrl_pkg::RESULT_ADDR: rd_next = result_reg;
			adc_ctrl_pkg::CLOCK_CONFIG_ADDR: rd_next = clk_cfg_read;
			adc_ctrl_pkg::IRQ_STATUS_ADDR: rd_next = irq_status_reg;
			adc_ctrl_pkg::IRQ_ENABLE_ADDR: rd_next = irq_enable_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= rd_i ? rd_next : 8'h00;
		end
	end

	// Analog front-end steering; unused and reserved codes select nothing
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			channel_select_o <= adc_ctrl_pkg::CHANNEL_POWER_OFF;
			power_down_o <= 1'b1;
			ref_high_sel_o <= 1'b0;
			ref_low_sel_o <= 1'b0;
			external_sel_o <= 1'b0;
		end else begin
			channel_select_o <= ctrl_reg.channel;
			power_down_o <= powered_off || stop_mode_i;
			ref_high_sel_o <= ctrl_reg.channel == adc_ctrl_pkg::CHANNEL_REF_HIGH;
			ref_low_sel_o <= ctrl_reg.channel == adc_ctrl_pkg::CHANNEL_REF_LOW;
			external_sel_o <= ctrl_reg.channel <= adc_ctrl_pkg::CHANNEL_LAST_EXTERNAL;
		end
	end

	// Sequencer view for the comparator and DAC
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sample_o <= 1'b0;
			dac_code_o <= 8'h00;
			busy_o <= 1'b0;
		end else begin
			sample_o <= state_reg == adc_ctrl_pkg::CONV_SAMPLE;
			dac_code_o <= trial_reg;
			busy_o <= state_reg != adc_ctrl_pkg::CONV_IDLE;
		end
	end

endmodule

// ### adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] STATUS_CONTROL_ADDR = 8'h38;
	localparam logic [7:0] RESULT_ADDR = 8'h39;
	localparam logic [7:0] CLOCK_CONFIG_ADDR = 8'h3A;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h3B;
	localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h3C;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h3D;

	// Status/control field positions
	localparam int DONE_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int CONT_BIT = 5;
	localparam int CHANNEL_LSB = 0;

	// Clock configuration field positions
	localparam int PRESCALE_LSB = 5;
	localparam int CLK_SRC_BIT = 4;

	// Event bits shared by irq status, clear and enable
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVERRUN_BIT = 1;
	localparam int IRQ_ABORT_BIT = 2;

	// Reset values
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1F;
	localparam logic [7:0] CLOCK_CONFIG_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h01;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// Channel codes
	localparam logic [4:0] CHANNEL_LAST_EXTERNAL = 5'h0B;
	localparam logic [4:0] CHANNEL_REF_HIGH = 5'h1D;
	localparam logic [4:0] CHANNEL_REF_LOW = 5'h1E;
	localparam logic [4:0] CHANNEL_POWER_OFF = 5'h1F;

	// Conversion timing in converter clock ticks
	localparam logic [3:0] SAMPLE_LAST_TICK = 4'h7;
	localparam logic [3:0] CONV_LAST_TICK = 4'hF;
	localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_SAMPLE,
		CONV_APPROX
	} conv_state_e;

	typedef struct packed {
		logic irq_enable;
		logic continuous;
		logic [4:0] channel;
	} ctrl_s;

	typedef struct packed {
		logic [2:0] prescale;
		logic source_bus;
	} clk_cfg_s;

	// Terminal count of the prescaler: divide by mask plus one
	function automatic logic [3:0] prescale_mask(input logic [2:0] code);
		logic [3:0] mask;
		mask = 4'hF;
		case (code)
			3'h0: mask = 4'h0;
			3'h1: mask = 4'h1;
			3'h2: mask = 4'h3;
			3'h3: mask = 4'h7;
			default: mask = 4'hF;
		endcase
		return mask;
	endfunction

	function automatic logic channel_off(input logic [4:0] channel);
		return channel == CHANNEL_POWER_OFF;
	endfunction

endpackage

// ### adc_ctrl_props.sv
`timescale 1ns/1ps
module adc_ctrl_props (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic irq_o,
	input wire logic stop_mode_i,
	input wire logic [4:0] channel_select_o,
	input wire logic power_down_o,
	input wire logic ref_high_sel_o,
	input wire logic ref_low_sel_o,
	input wire logic external_sel_o,
	input wire logic busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Busy length; a run cut by stop or a control write may legally be short
	logic [5:0] busy_cnt;
	logic cut_seen;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_cnt <= 6'h00;
			cut_seen <= 1'b0;
		end else if (!busy_o) begin
			busy_cnt <= 6'h00;
			cut_seen <= 1'b0;
		end else begin
			busy_cnt <= (busy_cnt == 6'h3F) ? busy_cnt : busy_cnt + 6'h01;
			cut_seen <= cut_seen | stop_mode_i | (wr_i && addr_i == 8'h38);
		end
	end

	power_map_a: assert property (
		channel_select_o == 5'h1F |-> power_down_o) else $error("off code not powered down");
	ref_select_a: assert property (
		ref_high_sel_o == (channel_select_o == 5'h1D) && ref_low_sel_o == (channel_select_o == 5'h1E))
		else $error("reference select mismatch");
	ext_select_a: assert property (
		external_sel_o == (channel_select_o <= 5'h0B)) else $error("external select mismatch");
	done_hidden_a: assert property (
		rd_i && addr_i == 8'h38 |=> !(rd_data_o[7] && rd_data_o[6]))
		else $error("done flag visible with irq enabled");
	irq_read_clear_a: assert property (
		(rd_i && addr_i == 8'h39 && !busy_o) ##1 !busy_o |=> !irq_o)
		else $error("irq held after result read");
	irq_write_clear_a: assert property (
		(wr_i && addr_i == 8'h38 && !busy_o) ##1 !busy_o |=> !irq_o)
		else $error("irq held after control write");
	conv_length_a: assert property (
		$fell(busy_o) && !cut_seen |-> busy_cnt >= 6'd15) else $error("conversion too short");
	stop_abort_a: assert property (
		stop_mode_i |-> ##[1:3] (!busy_o && power_down_o)) else $error("stop did not abort");
endmodule

bind adc_control_registers adc_ctrl_props adc_ctrl_props_i (.*);

// ### adc_prescaler.sv
`timescale 1ns/1ps
module adc_prescaler (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic crystal_clock_i,
	input wire adc_ctrl_pkg::clk_cfg_s cfg_i,
	output logic tick_o
);

	logic crystal_sync;
	logic crystal_last_reg;
	logic source_tick;
	logic [3:0] count_reg;
	logic [3:0] mask;

	adc_sync2 crystal_sync_inst (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(crystal_clock_i),
		.sync_o(crystal_sync)
	);

	// Crystal source counts its rising edges; bus source ticks every cycle
	assign source_tick = cfg_i.source_bus | (crystal_sync & ~crystal_last_reg);
	assign mask = adc_ctrl_pkg::prescale_mask(cfg_i.prescale);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			crystal_last_reg <= 1'b0;
		end else begin
			crystal_last_reg <= crystal_sync;
		end
	end

	// Divider; a mask change mid-count takes effect at once, a count at or past the new mask wrapping on the next source tick
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_reg <= 4'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (source_tick) begin
				if (count_reg >= mask) begin
					count_reg <= 4'h0;
					tick_o <= 1'b1;
				end else begin
					count_reg <= count_reg + 4'h1;
				end
			end
		end
	end

endmodule

// ### adc_sync2.sv
`timescale 1ns/1ps
module adc_sync2 (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic sync_o
);

	logic meta_reg;

	// Two stages; only the second stage is visible to the logic
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_reg <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk_i, reset_i, wr_i, rd_i, crystal_clock_i, stop_mode_i, comparator_i;
	logic [7:0] addr_i, wr_data_i, rd_data_o, dac_code_o, vin, rd_val;
	logic irq_o, power_down_o, ref_high_sel_o, ref_low_sel_o, external_sel_o, sample_o, busy_o;
	logic [4:0] channel_select_o;
	logic [1:0] xtal_cnt;
	int fail_count, checks, n;

	adc_control_registers adc_control_registers_i (.*);

	// Ideal comparator; only exact at divide 2 and up, since the trial code lags a cycle
	assign comparator_i = (vin >= dac_code_o);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Crystal at one sixth of the bus clock
	always @(posedge clk_i) begin
		xtal_cnt <= (xtal_cnt == 2'h2) ? 2'h0 : xtal_cnt + 2'h1;
		if (xtal_cnt == 2'h2) crystal_clock_i <= ~crystal_clock_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rd_val = rd_data_o;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus_read(a);
		check(rd_val, exp);
	endtask

	// Start a conversion and count the cycles that busy stays high
	task automatic run_conv(input logic [7:0] ctl);
		int i;
		bus_write(8'h38, ctl);
		#1;
		i = 0;
		while (!busy_o && i < 40) begin
			step(1);
			i++;
		end
		// The first busy cycle is a sample cycle
		check({7'h0, sample_o}, 8'h01);
		n = 0;
		while (busy_o && n < 600) begin
			step(1);
			n++;
		end
	endtask

	task automatic conv_len(input int d);
		check(8'(n >= 15 * d && n <= 17 * d + 6), 8'h01);
	endtask

	task automatic test_reset();
		check({3'h0, channel_select_o}, 8'h1F);
		check({7'h0, power_down_o}, 8'h01);
		rd_chk(8'h38, 8'h1F);
		rd_chk(8'h3A, 8'h00);
		rd_chk(8'h39, 8'h00);
		rd_chk(8'h3D, 8'h01);
		bus_write(8'h00, 8'hFF);
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h3A, 8'h00);
		$display("test_reset done");
	endtask

	task automatic test_single();
		bus_write(8'h3A, 8'h30); // Bus clock divided, crystal too slow here
		vin = 8'hA5;
		run_conv(8'h03); // Throwaway result after power-up
		run_conv(8'h03);
		conv_len(2);
		check({7'h0, external_sel_o}, 8'h01);
		rd_chk(8'h38, 8'h83);
		rd_chk(8'h39, 8'hA5);
		check(dac_code_o, 8'hA5);
		rd_chk(8'h38, 8'h03);
		step(40);
		check({7'h0, busy_o}, 8'h00);
		run_conv(8'h03);
		bus_write(8'h38, 8'h1F);
		rd_chk(8'h38, 8'h1F);
		$display("test_single done");
	endtask

	task automatic test_irq();
		vin = 8'h3C;
		run_conv(8'h5D);
		check({7'h0, ref_high_sel_o}, 8'h01);
		step(2);
		check({7'h0, irq_o}, 8'h01);
		rd_chk(8'h38, 8'h5D);
		rd_chk(8'h39, 8'h3C);
		step(2);
		check({7'h0, irq_o}, 8'h00);
		bus_write(8'h3D, 8'h00);
		run_conv(8'h5E);
		check({7'h0, ref_low_sel_o}, 8'h01);
		step(2);
		check({7'h0, irq_o}, 8'h00);
		// Earlier unread results left the overrun bit set; keep only the done bit
		bus_write(8'h3C, 8'hFE);
		rd_chk(8'h3B, 8'h01);
		bus_write(8'h3D, 8'h01);
		step(2);
		check({7'h0, irq_o}, 8'h01);
		bus_write(8'h3C, 8'h01);
		step(2);
		check({7'h0, irq_o}, 8'h00);
		$display("test_irq done");
	endtask

	task automatic test_continuous();
		bus_write(8'h3C, 8'hFF);
		vin = 8'h11;
		bus_write(8'h38, 8'h21);
		step(60);
		rd_chk(8'h39, 8'h11);
		vin = 8'h77;
		step(80);
		rd_chk(8'h38, 8'hA1);
		rd_chk(8'h39, 8'h77);
		bus_read(8'h3B);
		check(rd_val & 8'h02, 8'h02);
		@(posedge clk_i) stop_mode_i <= 1'b1;
		step(4);
		check({6'h0, power_down_o, busy_o}, 8'h02);
		vin = 8'h5A;
		@(posedge clk_i) stop_mode_i <= 1'b0;
		step(80);
		rd_chk(8'h39, 8'h5A);
		bus_write(8'h38, 8'h1F);
		step(3);
		check({6'h0, power_down_o, busy_o}, 8'h02);
		$display("test_continuous done");
	endtask

	// Clock settings change only between conversions
	task automatic test_divide();
		for (int c = 0; c < 8; c++) begin
			bus_write(8'h3A, {3'(c), 5'h10});
			run_conv(8'h0C);
			conv_len(c > 3 ? 16 : 1 << c);
		end
		check({7'h0, external_sel_o}, 8'h00);
		bus_write(8'h3A, 8'h00);
		run_conv(8'h0C);
		conv_len(6);
		$display("test_divide done");
	endtask

	task automatic conclude();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge clk_i);
		fail_count++;
		conclude();
	end

	initial begin
		reset_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wr_data_i = 8'h00;
		stop_mode_i = 1'b0;
		crystal_clock_i = 1'b0;
		xtal_cnt = 2'h0;
		vin = 8'h00;
		fail_count = 0;
		checks = 0;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		step(1);
		test_reset();
		test_single();
		test_irq();
		test_continuous();
		test_divide();
		conclude();
	end
endmodule
